// File: core/bao_top.sv
// Battery alert output block with AXI4-Lite register access
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Modes 0 and 1 drive the alert on port_a and mode 2 drives it on port_d.
// - Mode 3 (codes 43 and 93, expander with two-wire host) presents the alert on port_c.
// - Mode 4 (codes 44 and 94, expander with single-wire host) presents the alert on port_b.
// - After reset the mode is 0 so the alert goes to port_a.
// - An asserted alert pulls the selected port low, otherwise the port is released.
// - In mode 2 an asserted alert holds port_d low except during the once-per-second temperature sample.
// - The alert is the OR of every status flag ANDed with its enable mask bit.
// - The enable mask resets to zero so no flag raises the alert.
// - High mask byte bits 7..0 enable the overtemperature, voltage, inhibit and charge flags.
// - Low mask byte holds ocv taken at 7, condition 4, capacity alarm 2, eod 1, discharging 0.
// - Full charge sets on termination with setting -1, or when charge exceeds the setting.
// - The ocv taken flag clears on relaxation entry and sets when an ocv sample completes.
// - Charge inhibit sets on a charge request outside the temperature limits, voltage flags follow thresholds.
// - Config bits 2..0 hold the display and communication mode code 0 to 4.
// - Config bits 7..4 hold the external lamp count, passed unchanged to o_external_lamp_count, code 0 reserved.
module bao_top
	import bao_pkg::*;
#(
	parameter int TEMP_PERIOD = TEMP_PERIOD_CYC,
	parameter int TEMP_SAMPLE = TEMP_SAMPLE_CYC
)
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// AXI4-Lite write address
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [7:0] i_awaddr,
	// AXI4-Lite write data
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	// AXI4-Lite write response
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// AXI4-Lite read address
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [7:0] i_araddr,
	// AXI4-Lite read data
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// Gauge conditions
	input wire logic i_charge_overtemperature,
	input wire logic i_discharge_overtemperature,
	input wire logic i_charging_disallowed,
	input wire logic i_charging_allowed,
	input wire logic i_condition_flag,
	input wire logic i_capacity_alarm,
	input wire logic i_end_of_discharge,
	input wire logic i_discharging,
	input wire logic i_charge_terminated,
	input wire logic i_charge_request,
	input wire logic i_relaxation_state_entry,
	input wire logic i_ocv_done,
	input wire logic [7:0] i_soc_percent,
	input wire logic [15:0] i_voltage,
	input wire logic signed [15:0] i_temperature,
	// Alert ports, open drain
	output logic o_port_a_out,
	output logic o_port_a_oe,
	output logic o_port_b_out,
	output logic o_port_b_oe,
	output logic o_port_c_out,
	output logic o_port_c_oe,
	output logic o_port_d_out,
	output logic o_port_d_oe,
	// Status
	output logic o_thermistor_sense,
	output logic [3:0] o_external_lamp_count
);

	logic [15:0] alert_enable_mask;
	logic [7:0] display_comm_config;
	logic [7:0] full_threshold_percent;
	logic [31:0] volt_lim;
	logic [31:0] temp_lim;
	logic [15:0] flags;
	logic alert;
	logic [26:0] temp_cnt;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [2:0] mode_code;
	bao_mode_e display_mode_code;
	logic [3:0] port_sel;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic addr_known(input logic [7:0] a);
		unique case (a)
			OFF_MASK, OFF_CONFIG, OFF_FULL_PCT, OFF_VOLT_LIM,
			OFF_TEMP_LIM, OFF_FLAGS, OFF_STATUS: addr_known = 1'b1;
			default: addr_known = 1'b0;
		endcase
	endfunction : addr_known

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		merge = r;
	endfunction : merge

	// ****************************************************************
	// Write channel
	// ****************************************************************
	assign o_awready = !aw_held && !o_bvalid;
	assign o_wready = !w_held && !o_bvalid;
	assign do_write = aw_held && w_held && !o_bvalid;

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end
		else if (i_awvalid && o_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= i_awaddr;
		end
		else if (do_write)
			aw_held <= 1'b0;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else if (i_wvalid && o_wready)
		begin
			w_held <= 1'b1;
			w_data <= i_wdata;
			w_strb <= i_wstrb;
		end
		else if (do_write)
			w_held <= 1'b0;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end
		else if (do_write)
		begin
			o_bvalid <= 1'b1;
			o_bresp <= addr_known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (i_bready)
			o_bvalid <= 1'b0;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			alert_enable_mask <= RST_MASK;
			display_comm_config <= RST_CONFIG;
			full_threshold_percent <= RST_FULL_PCT;
			volt_lim <= RST_VOLT_LIM;
			temp_lim <= RST_TEMP_LIM;
		end
		else if (do_write)
		begin
			unique case (aw_addr)
				OFF_MASK: alert_enable_mask <= 16'(merge({16'h0000, alert_enable_mask},
					w_data, w_strb));
				OFF_CONFIG: display_comm_config <= 8'(merge({24'h000000, display_comm_config},
					w_data, w_strb));
				OFF_FULL_PCT: full_threshold_percent <= 8'(merge({24'h000000,
					full_threshold_percent}, w_data, w_strb));
				OFF_VOLT_LIM: volt_lim <= merge(volt_lim, w_data, w_strb);
				OFF_TEMP_LIM: temp_lim <= merge(temp_lim, w_data, w_strb);
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Read channel
	// ****************************************************************
	assign o_arready = !o_rvalid;

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h00000000;
			o_rresp <= RESP_OKAY;
		end
		else if (i_arvalid && o_arready)
		begin
			o_rvalid <= 1'b1;
			o_rresp <= addr_known(i_araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (i_araddr)
				OFF_MASK: o_rdata <= {16'h0000, alert_enable_mask};
				OFF_CONFIG: o_rdata <= {24'h000000, display_comm_config};
				OFF_FULL_PCT: o_rdata <= {24'h000000, full_threshold_percent};
				OFF_VOLT_LIM: o_rdata <= volt_lim;
				OFF_TEMP_LIM: o_rdata <= temp_lim;
				OFF_FLAGS: o_rdata <= {16'h0000, flags};
				OFF_STATUS: o_rdata <= {30'h0, o_thermistor_sense, alert};
				default: o_rdata <= 32'h00000000;
			endcase
		end
		else if (i_rready)
			o_rvalid <= 1'b0;
	end

	// ****************************************************************
	// Flag word
	// ****************************************************************
	bao_flags u_flags (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_charge_overtemperature(i_charge_overtemperature),
		.i_discharge_overtemperature(i_discharge_overtemperature),
		.i_charging_disallowed(i_charging_disallowed),
		.i_charging_allowed(i_charging_allowed),
		.i_condition_flag(i_condition_flag),
		.i_capacity_alarm(i_capacity_alarm),
		.i_end_of_discharge(i_end_of_discharge),
		.i_discharging(i_discharging),
		.i_charge_terminated(i_charge_terminated),
		.i_charge_request(i_charge_request),
		.i_relaxation_state_entry(i_relaxation_state_entry),
		.i_ocv_done(i_ocv_done),
		.i_soc_percent(i_soc_percent),
		.i_voltage(i_voltage),
		.i_temperature(i_temperature),
		.i_full_threshold_percent(full_threshold_percent),
		.i_volt_lim(volt_lim),
		.i_temp_lim(temp_lim),
		.o_flags(flags)
	);

	// ****************************************************************
	// Alert and mode decode
	// ****************************************************************
	assign alert = |(flags & alert_enable_mask & FLAG_VALID);
	assign mode_code = display_comm_config[CFG_MODE_LSB +: CFG_MODE_W];
	assign o_external_lamp_count = display_comm_config[CFG_LAMP_LSB +: CFG_LAMP_W];

	always_comb
	begin
		display_mode_code = BAO_MODE_NONE;
		port_sel = 4'b0000;
		unique case (mode_code)
			3'd0: port_sel = 4'b0001;
			3'd1:
			begin
				display_mode_code = BAO_MODE_SINGLE;
				port_sel = 4'b0001;
			end
			3'd2:
			begin
				display_mode_code = BAO_MODE_FOUR;
				port_sel = 4'b1000;
			end
			3'd3:
			begin
				display_mode_code = BAO_MODE_EXP_TWO;
				port_sel = 4'b0100;
			end
			3'd4:
			begin
				display_mode_code = BAO_MODE_EXP_ONE;
				port_sel = 4'b0010;
			end
			default: port_sel = 4'b0000;
		endcase
	end

	// ****************************************************************
	// Temperature sample timing
	// ****************************************************************
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			temp_cnt <= 27'd0;
		else if (temp_cnt == 27'(TEMP_PERIOD - 1))
			temp_cnt <= 27'd0;
		else
			temp_cnt <= temp_cnt + 27'd1;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			o_thermistor_sense <= 1'b0;
		else
			o_thermistor_sense <= (temp_cnt < 27'(TEMP_SAMPLE)) &&
				(display_mode_code == BAO_MODE_FOUR);
	end

	// ****************************************************************
	// Port drivers
	// ****************************************************************
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_port_a_oe <= 1'b0;
			o_port_b_oe <= 1'b0;
			o_port_c_oe <= 1'b0;
			o_port_d_oe <= 1'b0;
		end
		else
		begin
			o_port_a_oe <= alert && port_sel[0];
			o_port_b_oe <= alert && port_sel[1];
			o_port_c_oe <= alert && port_sel[2];
			o_port_d_oe <= alert && port_sel[3] &&
				!((temp_cnt < 27'(TEMP_SAMPLE)));
		end
	end

	assign o_port_a_out = 1'b0;
	assign o_port_b_out = 1'b0;
	assign o_port_c_out = 1'b0;
	assign o_port_d_out = 1'b0;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	mask_reset_a: assert property ($rose(i_rst_n) |-> alert_enable_mask == 16'h0000)
		else $error("mask not zero after reset");
	mode_reset_a: assert property ($rose(i_rst_n) |-> mode_code == 3'd0)
		else $error("mode not zero after reset");
	port_a_route_a: assert property (alert && mode_code <= 3'd1 |=> o_port_a_oe && !o_port_b_oe && !o_port_c_oe && !o_port_d_oe)
		else $error("alert not on port a");
	port_c_route_a: assert property (alert && mode_code == 3'd3 |=> o_port_c_oe && !o_port_a_oe)
		else $error("alert not on port c");
	port_b_route_a: assert property (alert && mode_code == 3'd4 |=> o_port_b_oe && !o_port_a_oe)
		else $error("alert not on port b");
	idle_release_a: assert property (!alert |=> !o_port_a_oe && !o_port_b_oe && !o_port_c_oe && !o_port_d_oe)
		else $error("port driven without alert");
	sample_release_a: assert property (o_thermistor_sense |-> !o_port_d_oe)
		else $error("port d driven during temperature sample");
	alert_or_a: assert property (alert == |(flags & alert_enable_mask & 16'hFF97))
		else $error("alert differs from masked flags");
	reserved_mask_a: assert property ((flags & alert_enable_mask & 16'hFF97) == 16'h0000 |-> !alert)
		else $error("reserved bit raised alert");
	write_resp_a: assert property (do_write |=> o_bvalid)
		else $error("write response missing");

	four_lamp_c: cover property (alert && mode_code == 3'd2 ##1 o_port_d_oe);
	expander_c: cover property (alert && mode_code == 3'd3 ##1 o_port_c_oe);
	single_wire_c: cover property (alert && mode_code == 3'd4 ##1 o_port_b_oe);

endmodule : bao_top
`default_nettype wire

// File: core/bao_pkg.sv
// Package of constants and types for the battery alert output block
package bao_pkg;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFF_MASK = 8'h00;
	localparam logic [7:0] OFF_CONFIG = 8'h04;
	localparam logic [7:0] OFF_FULL_PCT = 8'h08;
	localparam logic [7:0] OFF_VOLT_LIM = 8'h0C;
	localparam logic [7:0] OFF_TEMP_LIM = 8'h10;
	localparam logic [7:0] OFF_FLAGS = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [15:0] RST_MASK = 16'h0000;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_FULL_PCT = 8'hFF;
	localparam logic [31:0] RST_VOLT_LIM = 32'hFFFF0000;
	localparam logic [31:0] RST_TEMP_LIM = 32'h7FFF8000;

	// ****************************************************************
	// Flag word bit positions
	// ****************************************************************
	localparam int FB_CHG_OT = 15;
	localparam int FB_DSG_OT = 14;
	localparam int FB_HIGH_V = 13;
	localparam int FB_LOW_V = 12;
	localparam int FB_INHIBIT = 11;
	localparam int FB_NO_CHG = 10;
	localparam int FB_FULL = 9;
	localparam int FB_CHG_OK = 8;
	localparam int FB_OCV = 7;
	localparam int FB_COND = 4;
	localparam int FB_CAP_ALM = 2;
	localparam int FB_END_DSG = 1;
	localparam int FB_DISCH = 0;
	localparam logic [15:0] FLAG_VALID = 16'hFF97;

	// ****************************************************************
	// Config byte fields
	// ****************************************************************
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_MODE_W = 3;
	localparam int CFG_LAMP_LSB = 4;
	localparam int CFG_LAMP_W = 4;
	localparam logic [7:0] FULL_PCT_OFF = 8'hFF;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ = 125_000_000;
	localparam int TEMP_PERIOD_MS = 1000;
	localparam int TEMP_SAMPLE_US = 100;
	localparam int TEMP_PERIOD_CYC = (CLK_HZ / 1000) * TEMP_PERIOD_MS;
	localparam int TEMP_SAMPLE_CYC = (CLK_HZ / 1_000_000) * TEMP_SAMPLE_US;

	// ****************************************************************
	// Display and communication modes
	// ****************************************************************
	typedef enum logic [2:0] {
		BAO_MODE_NONE,
		BAO_MODE_SINGLE,
		BAO_MODE_FOUR,
		BAO_MODE_EXP_TWO,
		BAO_MODE_EXP_ONE
	} bao_mode_e;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : bao_pkg

// File: core/bao_flags.sv
// Status flag word generator for the battery alert output block
`timescale 1ns/1ps
`default_nettype none
module bao_flags
	import bao_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Gauge conditions
	input wire logic i_charge_overtemperature,
	input wire logic i_discharge_overtemperature,
	input wire logic i_charging_disallowed,
	input wire logic i_charging_allowed,
	input wire logic i_condition_flag,
	input wire logic i_capacity_alarm,
	input wire logic i_end_of_discharge,
	input wire logic i_discharging,
	input wire logic i_charge_terminated,
	input wire logic i_charge_request,
	input wire logic i_relaxation_state_entry,
	input wire logic i_ocv_done,
	input wire logic [7:0] i_soc_percent,
	input wire logic [15:0] i_voltage,
	input wire logic signed [15:0] i_temperature,
	// Settings
	input wire logic [7:0] i_full_threshold_percent,
	input wire logic [31:0] i_volt_lim,
	input wire logic [31:0] i_temp_lim,
	// Flag word
	output logic [15:0] o_flags
);

	logic ocv_taken_a;
	logic full_charge;
	logic inhibit;

	// ****************************************************************
	// Flag terms
	// ****************************************************************
	always_comb
	begin
		if (i_full_threshold_percent == FULL_PCT_OFF)
			full_charge = i_charge_terminated;
		else
			full_charge = $signed({1'b0, i_soc_percent}) >
				$signed({i_full_threshold_percent[7], i_full_threshold_percent});
		inhibit = i_charge_request && ((i_temperature < $signed(i_temp_lim[15:0])) ||
			(i_temperature > $signed(i_temp_lim[31:16])));
	end

	// Set wins over the clear on relaxation entry
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			ocv_taken_a <= 1'b0;
		else if (i_ocv_done)
			ocv_taken_a <= 1'b1;
		else if (i_relaxation_state_entry)
			ocv_taken_a <= 1'b0;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			o_flags <= 16'h0000;
		else
		begin
			o_flags <= 16'h0000;
			o_flags[FB_CHG_OT] <= i_charge_overtemperature;
			o_flags[FB_DSG_OT] <= i_discharge_overtemperature;
			o_flags[FB_HIGH_V] <= i_voltage > i_volt_lim[31:16];
			o_flags[FB_LOW_V] <= i_voltage < i_volt_lim[15:0];
			o_flags[FB_INHIBIT] <= inhibit;
			o_flags[FB_NO_CHG] <= i_charging_disallowed;
			o_flags[FB_FULL] <= full_charge;
			o_flags[FB_CHG_OK] <= i_charging_allowed;
			o_flags[FB_OCV] <= ocv_taken_a;
			o_flags[FB_COND] <= i_condition_flag;
			o_flags[FB_CAP_ALM] <= i_capacity_alarm;
			o_flags[FB_END_DSG] <= i_end_of_discharge;
			o_flags[FB_DISCH] <= i_discharging;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	ocv_set_a: assert property (i_ocv_done |=> ##1 o_flags[FB_OCV])
		else $error("ocv flag not set after measurement");
	ocv_clear_a: assert property (i_relaxation_state_entry && !i_ocv_done |=> ##1 !o_flags[FB_OCV])
		else $error("ocv flag not cleared on relaxation entry");
	full_term_a: assert property ((i_full_threshold_percent == FULL_PCT_OFF) && $stable(i_full_threshold_percent) && i_charge_terminated |=> o_flags[FB_FULL])
		else $error("full charge not set on termination");
	reserved_zero_a: assert property ((o_flags & ~FLAG_VALID) == 16'h0000)
		else $error("reserved flag bit set");

endmodule : bao_flags
`default_nettype wire

// File: dv/bao_host.sv
// Host model that senses the open-drain alert lines
`timescale 1ns/1ps
`default_nettype none
module bao_host
(
	// Drive side of the four ports
	input wire logic [3:0] i_oe,
	input wire logic [3:0] i_out,
	// Levels seen by the host
	output logic [3:0] o_line
);
	// ****************************************************************
	// Pull-ups: a released line reads high, a driven one reads low
	// ****************************************************************
	assign o_line = (i_oe & i_out) | ~i_oe;
endmodule : bao_host
`default_nettype wire

// File: dv/tb.sv
// Testbench for the battery alert output block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bao_pkg::*;
	localparam int TP = 200;
	localparam int SMP = 10;
	localparam int POS [8] = '{0, 1, 2, 4, 8, 10, 14, 15};
	localparam logic [7:0] CFGS [7] = '{8'h00, 8'h01, 8'h02, 8'h43, 8'h93, 8'h44, 8'h94};
	localparam int PT [7] = '{0, 0, 3, 2, 2, 1, 1};
	logic i_clock = 1'h0;
	logic i_rst_n = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, lv = 8'h00, soc = 8'h00;
	logic [31:0] wdata = 32'h0, d;
	logic term = 1'h0, creq = 1'h0, relaxation_state = 1'h0, ocv = 1'h0;
	logic [15:0] volt = 16'h0000, temp = 16'h0000;
	logic [1:0] r;
	wire awready, wready, bvalid, arready, rvalid, tsense;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [3:0] oe, pout, line, lamps;
	int fail_count = 0;
	int cmp_count = 0;
	int i, n, m;

	bao_top #(.TEMP_PERIOD(TP), .TEMP_SAMPLE(SMP)) i_bao_top (
		.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
		.i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF),
		.o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
		.o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
		.i_charge_overtemperature(lv[7]), .i_discharge_overtemperature(lv[6]),
		.i_charging_disallowed(lv[5]), .i_charging_allowed(lv[4]),
		.i_condition_flag(lv[3]), .i_capacity_alarm(lv[2]),
		.i_end_of_discharge(lv[1]), .i_discharging(lv[0]),
		.i_charge_terminated(term), .i_charge_request(creq),
		.i_relaxation_state_entry(relaxation_state), .i_ocv_done(ocv), .i_soc_percent(soc),
		.i_voltage(volt), .i_temperature(temp),
		.o_port_a_out(pout[0]), .o_port_a_oe(oe[0]), .o_port_b_out(pout[1]), .o_port_b_oe(oe[1]),
		.o_port_c_out(pout[2]), .o_port_c_oe(oe[2]), .o_port_d_out(pout[3]), .o_port_d_oe(oe[3]),
		.o_thermistor_sense(tsense), .o_external_lamp_count(lamps));

	bao_host i_bao_host (.i_oe(oe), .i_out(pout), .o_line(line));

	initial forever #4 i_clock = ~i_clock;

	// ****************************************************************
	// Reporting
	// ****************************************************************
	task automatic finish_test;
		$display("Compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tmo;
		fail_count++;
		$display("BAD bus wait expected answer seen none");
		finish_test();
	endtask : tmo

	// ****************************************************************
	// Bus access
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		int k;
		logic done;
		k = 0;
		done = 1'h0;
		@(posedge i_clock);
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		awaddr <= a;
		wdata <= dv;
		bready <= 1'h1;
		while (!done)
		begin
			@(posedge i_clock);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid === 1'h1)
			begin
				done = 1'h1;
				bready <= 1'h0;
				chk("bresp", {30'h0, bresp}, {30'h0, RESP_OKAY});
			end
			k++;
			if (k > 100) tmo();
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] dq, output logic [1:0] rq);
		int k;
		logic done;
		k = 0;
		done = 1'h0;
		dq = 32'h0;
		rq = 2'h0;
		@(posedge i_clock);
		arvalid <= 1'h1;
		araddr <= a;
		rready <= 1'h1;
		while (!done)
		begin
			@(posedge i_clock);
			if (arvalid && arready) arvalid <= 1'h0;
			if (rvalid === 1'h1)
			begin
				done = 1'h1;
				rready <= 1'h0;
				dq = rdata;
				rq = rresp;
			end
			k++;
			if (k > 100) tmo();
		end
	endtask : rd

	task automatic wt(input int c);
		repeat (c) @(posedge i_clock);
		#1;
	endtask : wt

	task automatic al(input logic [3:0] e);
		wt(4);
		chk("lines", {28'h0, line}, {28'h0, e});
	endtask : al

	task automatic fl(input logic [15:0] msk, input logic [15:0] e);
		wt(3);
		rd(OFF_FLAGS, d, r);
		chk("flags", d & {16'h0, msk}, {16'h0, e});
	endtask : fl

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'h1;
		rd(OFF_MASK, d, r);
		chk("mask reset", d, 32'h0);
		rd(OFF_CONFIG, d, r);
		chk("config reset", d, 32'h0);
		@(posedge i_clock);
		lv <= 8'hFF;
		al(4'hF);
		wr(OFF_MASK, 32'h0068);
		al(4'hF);
		for (i = 0; i < 8; i++)
		begin
			@(posedge i_clock);
			lv <= 8'h01 << i;
			wr(OFF_MASK, 32'h1 << POS[i]);
			al(4'hE);
			wr(OFF_MASK, ~(32'h1 << POS[i]) & 32'hFFFF);
			al(4'hF);
		end
		wr(OFF_MASK, 32'h8000);
		for (i = 0; i < 7; i++)
		begin
			wr(OFF_CONFIG, {24'h0, CFGS[i]});
			if (PT[i] == 3)
			begin
				n = 0;
				m = 0;
				wt(3);
				repeat (TP)
				begin
					@(posedge i_clock);
					#1;
					n += int'(line[3] === 1'h0);
					m += int'(tsense === 1'h1);
				end
				chk("port_d low", 32'(n), 32'(TP - SMP));
				chk("sense", 32'(m), 32'(SMP));
				chk("other lines", {29'h0, line[2:0]}, 32'h7);
			end
			else
				al(~(4'h1 << PT[i]));
			chk("lamps", {28'h0, lamps}, {28'h0, CFGS[i][7:4]});
		end
		wr(OFF_MASK, 32'h0);
		@(posedge i_clock);
		lv <= 8'h00;
		term <= 1'h1;
		fl(16'h0200, 16'h0200);
		wr(OFF_FULL_PCT, 32'h32);
		fl(16'h0200, 16'h0000);
		@(posedge i_clock);
		soc <= 8'h33;
		fl(16'h0200, 16'h0200);
		wr(OFF_VOLT_LIM, 32'h00C80064);
		@(posedge i_clock);
		volt <= 16'h00C9;
		fl(16'h3000, 16'h2000);
		@(posedge i_clock);
		volt <= 16'h0063;
		fl(16'h3000, 16'h1000);
		@(posedge i_clock);
		volt <= 16'h0096;
		fl(16'h3000, 16'h0000);
		wr(OFF_TEMP_LIM, 32'h0028FFF6);
		@(posedge i_clock);
		creq <= 1'h1;
		temp <= 16'h0032;
		fl(16'h0800, 16'h0800);
		@(posedge i_clock);
		temp <= 16'h0014;
		fl(16'h0800, 16'h0000);
		@(posedge i_clock);
		temp <= 16'hFFEC;
		fl(16'h0800, 16'h0800);
		@(posedge i_clock);
		ocv <= 1'h1;
		@(posedge i_clock);
		ocv <= 1'h0;
		fl(16'h0080, 16'h0080);
		@(posedge i_clock);
		relaxation_state <= 1'h1;
		@(posedge i_clock);
		relaxation_state <= 1'h0;
		fl(16'h0080, 16'h0000);
		rd(8'h1C, d, r);
		chk("unmapped data", d, 32'h0);
		chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
		finish_test();
	end
endmodule : tb
`default_nettype wire
